// ### shared/fhd_pkg.sv
// fhd_pkg: constants, codes and state types for the diagnostic sequencer
// assumes a 100 MHz core clock
package fhd_pkg;
    localparam int CLK_MHZ = 100;
    localparam int LOAD_MS = 100;
    localparam int STEP_MS = 70;
    localparam int PLL_MS = 50;
    localparam int CYC_PER_MS = CLK_MHZ * 1000;
    localparam int LOAD_CYC = LOAD_MS * CYC_PER_MS;
    localparam int STEP_CYC = STEP_MS * CYC_PER_MS;
    localparam int PLL_CYC = PLL_MS * CYC_PER_MS;
    // test codes, switch 1 is msb
    localparam logic [4:0] TC_HEADLOAD = 5'h04;
    localparam logic [4:0] TC_TRK00 = 5'h05;
    localparam logic [4:0] TC_SEEK01 = 5'h06;
    localparam logic [4:0] TC_SEEK02 = 5'h07;
    localparam logic [4:0] TC_SEEK38 = 5'h08;
    localparam logic [4:0] TC_SEEK76 = 5'h09;
    localparam logic [4:0] TC_RWCTL = 5'h0c;
    localparam logic [4:0] TC_PLLCRC = 5'h0d;
    localparam logic [4:0] TC_CABLE = 5'h0e;
    localparam logic [4:0] TC_STLOOP = 5'h0f;
    localparam logic [4:0] TC_ECHO = 5'h10;
    localparam logic [4:0] TC_BFSEEK = 5'h11;
    localparam logic [4:0] TC_SEQSCAN = 5'h12;
    localparam logic [4:0] TC_BFSCAN = 5'h13;
    localparam logic [4:0] TC_WRRD = 5'h18;
    localparam logic [4:0] TC_FMT = 5'h19;
    localparam logic [4:0] TC_DENS_SD = 5'h1a;
    localparam logic [4:0] TC_DENS_DD = 5'h1b;
    localparam logic [4:0] TC_EXER_F = 5'h1e;
    localparam logic [4:0] TC_EXER = 5'h1f;
    // error codes on leds 5..8
    localparam logic [3:0] ERR_CABLE_HOST = 4'h3;
    localparam logic [3:0] ERR_CABLE_DRIVE = 4'h4;
    localparam logic [3:0] ERR_PLL = 4'ha;
    localparam logic [3:0] ERR_RWCTL = 4'hb;
    localparam logic [3:0] ERR_CRC = 4'hc;
    localparam logic [3:0] ERR_SWITCH = 4'he;
    // density codes on leds 5,6
    localparam logic [1:0] DENS_UNKNOWN = 2'h0;
    localparam logic [1:0] DENS_SINGLE = 2'h1;
    localparam logic [1:0] DENS_DOUBLE = 2'h2;
    localparam logic [6:0] TRK_01 = 7'h01;
    localparam logic [6:0] TRK_02 = 7'h02;
    localparam logic [6:0] TRK_38 = 7'h26;
    localparam logic [6:0] TRK_76 = 7'h4c;
    typedef enum logic [8:0] {
        ST_LATCH = 9'h001,
        ST_SELF = 9'h002,
        ST_DISPATCH = 9'h004,
        ST_HOME = 9'h008,
        ST_SEEK = 9'h010,
        ST_RUN = 9'h020,
        ST_CHECK = 9'h040,
        ST_HALT = 9'h080,
        ST_NORMAL = 9'h100
    } fhd_state_e;
endpackage

// ### hw/fhd_sequencer.sv
// fhd_sequencer: stand-alone diagnostic sequencer of a two-drive disk controller
// assumes all inputs synchronous to core_clk_in; drives wired as step/dir/head-load
//
// Contract
// - finish hardware self-test after power-up before the selected routine
// - on failure show four-bit code on leds 5-8, halt, run led dark
// - led 2 lit after self-test halt and most routine halts, unlit after cable halts
// - while running cleanly leds 5-6 show density, leds 7-8 drive
// - density: off/off unknown, led 6 single, led 5 double
// - led 7 off; led 8 off for drive 0, on for drive 1
// - codes 00100-01001: head load, track 00, seek 01/02/38/76
// - codes 01100-01111: rw controller, pll/crc, cable, self-test loop
// - codes 10000-10011, 11000-11011, 11110-11111 assigned; others unassigned
// - head-load routine homes, then load 100 ms, unload 100 ms forever
// - track-00 routine homes, head loaded, steps 01/02 every 70 ms
// - fixed-track routine homes, seeks target, loads head, holds forever
// - rw controller test repeats self-test; failure halts code 1011, led 2
// - pll test counts oscillator cycles 50 ms; out of range halts 1010
// - then crc/serial path check; failure halts 1100 with led 2
// - self-test runs once after each power-up in ordinary operation
// - self-test loop repeats until error, toggling leds 5, 7, 8
// - switches 1-5 form code, switch 1 msb; top three zero is normal
// - switch 8 selects drive 0 or drive 1
// - cable failure: 0011 host link cable, 0100 drive bus cable
// - led 3 lit while writing, led 4 lit while reading
`timescale 1ns/1ps
`default_nettype none
module fhd_sequencer #(
    parameter int LOAD_CYCLES = fhd_pkg::LOAD_CYC,
    parameter int STEP_CYCLES = fhd_pkg::STEP_CYC,
    parameter int PLL_CYCLES = fhd_pkg::PLL_CYC,
    parameter int STEP_GAP = 16,
    parameter logic [23:0] PLL_MIN = 24'h100000,
    parameter logic [23:0] PLL_MAX = 24'h200000
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    // operator switches, bit 7 is switch 1
    input wire logic [7:0] switch_in,
    // self-test results from the controller hardware
    input wire logic self_test_done_in,
    input wire logic self_test_fail_in,
    input wire logic [3:0] self_test_code_in,
    input wire logic rw_test_done_in,
    input wire logic rw_test_fail_in,
    input wire logic loop_oscillator_in,
    input wire logic crc_test_done_in,
    input wire logic crc_test_fail_in,
    input wire logic cable_test_done_in,
    input wire logic host_link_cable_fail_in,
    input wire logic drive_cable_fail_in,
    // datapath activity
    input wire logic writing_in,
    input wire logic reading_in,
    input wire logic [1:0] density_in,
    // drive positioner
    input wire logic track_zero_in,
    output logic [1:0] drive_sel_out,
    output logic step_out,
    output logic dir_in_out,
    output logic head_load_out,
    // test starts
    output logic self_test_start_out,
    output logic rw_test_start_out,
    output logic crc_test_start_out,
    output logic cable_test_start_out,
    output logic normal_mode_out,
    // indicators, bit 0 is led 1
    output logic [7:0] led_out,
    output logic run_led_out
);
    import fhd_pkg::*;

    // ==========================================================
    // reset release
    logic [1:0] rst_sync_reg;
    logic rst_n;
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    function automatic logic routine_assigned(input logic [4:0] c);
        return (c >= TC_HEADLOAD && c <= TC_SEEK76) || (c >= TC_RWCTL && c <= TC_BFSCAN) ||
               (c >= TC_WRRD && c <= TC_DENS_DD) || c == TC_EXER_F || c == TC_EXER;
    endfunction

    function automatic logic [6:0] target_track(input logic [4:0] c);
        unique case (c)
            TC_SEEK02: return TRK_02;
            TC_SEEK38: return TRK_38;
            TC_SEEK76: return TRK_76;
            default: return TRK_01;
        endcase
    endfunction

    // ==========================================================
    // state
    fhd_state_e state_reg;
    logic [4:0] code_reg;
    logic drive_reg;
    logic [7:0] echo_reg;
    logic [3:0] err_reg;
    logic self_err_reg;
    logic [31:0] timer_reg;
    logic [23:0] osc_cnt_reg;
    logic osc_prev_reg;
    logic [6:0] track_reg;
    logic [6:0] goal_reg;
    logic head_reg;
    logic step_reg;
    logic dir_reg;
    logic toggle_reg;
    logic phase_reg;
    logic self_loop;
    logic timer_hit;
    logic [31:0] timer_lim;

    assign self_loop = (code_reg == TC_STLOOP);
    assign timer_lim = (code_reg == TC_PLLCRC) ? 32'(PLL_CYCLES) :
                       (code_reg == TC_TRK00) ? 32'(STEP_CYCLES) :
                       (state_reg == ST_RUN) ? 32'(LOAD_CYCLES) : 32'(STEP_GAP);
    assign timer_hit = (timer_reg >= timer_lim - 32'h1);

    // ==========================================================
    // sequencer
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_LATCH;
            code_reg <= 5'h0;
            drive_reg <= 1'b0;
            err_reg <= 4'h0;
            self_err_reg <= 1'b0;
            phase_reg <= 1'b0;
            toggle_reg <= 1'b0;
        end else if (clk_en_in) begin
            unique case (state_reg)
                ST_LATCH: begin
                    code_reg <= switch_in[7:3];
                    drive_reg <= switch_in[0];
                    state_reg <= ST_SELF;
                end
                ST_SELF: begin
                    if (self_test_done_in) begin
                        if (self_test_fail_in) begin
                            err_reg <= self_test_code_in;
                            self_err_reg <= 1'b1;
                            state_reg <= ST_HALT;
                        end else if (self_loop) begin
                            toggle_reg <= ~toggle_reg;
                        end else begin
                            state_reg <= ST_DISPATCH;
                        end
                    end
                end
                ST_DISPATCH: begin
                    phase_reg <= 1'b0;
                    if (code_reg[4:2] == 3'h0) begin
                        state_reg <= ST_NORMAL;
                    end else if (!routine_assigned(code_reg)) begin
                        err_reg <= ERR_SWITCH;
                        self_err_reg <= 1'b1;
                        state_reg <= ST_HALT;
                    end else if (code_reg <= TC_SEEK76) begin
                        state_reg <= ST_HOME;
                    end else begin
                        state_reg <= ST_CHECK;
                    end
                end
                ST_HOME: begin
                    if (track_zero_in) begin
                        state_reg <= (code_reg != TC_HEADLOAD) ? ST_SEEK : ST_RUN;
                    end
                end
                ST_SEEK: begin
                    if (track_reg == goal_reg && timer_hit) begin
                        state_reg <= ST_RUN;
                    end
                end
                ST_RUN: phase_reg <= phase_reg ^ timer_hit;
                ST_CHECK: begin
                    unique case (code_reg)
                        TC_RWCTL: begin
                            if (rw_test_done_in && rw_test_fail_in) begin
                                err_reg <= ERR_RWCTL;
                                self_err_reg <= 1'b1;
                                state_reg <= ST_HALT;
                            end
                        end
                        TC_PLLCRC: begin
                            if (!phase_reg && timer_hit) begin
                                if (osc_cnt_reg < PLL_MIN || osc_cnt_reg > PLL_MAX) begin
                                    err_reg <= ERR_PLL;
                                    self_err_reg <= 1'b1;
                                    state_reg <= ST_HALT;
                                end else begin
                                    phase_reg <= 1'b1;
                                end
                            end else if (phase_reg && crc_test_done_in) begin
                                if (crc_test_fail_in) begin
                                    err_reg <= ERR_CRC;
                                    self_err_reg <= 1'b1;
                                    state_reg <= ST_HALT;
                                end else begin
                                    phase_reg <= 1'b0;
                                end
                            end
                        end
                        TC_CABLE: begin
                            if (cable_test_done_in) begin
                                if (host_link_cable_fail_in) begin
                                    err_reg <= ERR_CABLE_HOST;
                                    state_reg <= ST_HALT;
                                end else if (drive_cable_fail_in) begin
                                    err_reg <= ERR_CABLE_DRIVE;
                                    state_reg <= ST_HALT;
                                end
                            end
                        end
                        default: begin
                        end
                    endcase
                end
                ST_HALT, ST_NORMAL: begin
                end
            endcase
        end
    end

    // ==========================================================
    // timer and positioner
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            timer_reg <= 32'h0;
        end else if (clk_en_in) begin
            if (timer_hit || state_reg == ST_DISPATCH ||
                (state_reg == ST_HOME && track_zero_in)) begin
                timer_reg <= 32'h0;
            end else begin
                timer_reg <= timer_reg + 32'h1;
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            track_reg <= 7'h0;
            goal_reg <= 7'h0;
            step_reg <= 1'b0;
            dir_reg <= 1'b0;
            head_reg <= 1'b0;
        end else if (clk_en_in) begin
            step_reg <= 1'b0;
            unique case (state_reg)
                ST_HOME: begin
                    dir_reg <= 1'b0;
                    track_reg <= 7'h0;
                    goal_reg <= target_track(code_reg);
                    if (!track_zero_in && timer_hit) begin
                        step_reg <= 1'b1;
                    end
                end
                ST_SEEK: begin
                    dir_reg <= 1'b1;
                    if (track_reg != goal_reg && timer_hit) begin
                        step_reg <= 1'b1;
                        track_reg <= track_reg + 7'h1;
                    end
                end
                ST_RUN: begin
                    if (code_reg == TC_HEADLOAD) begin
                        head_reg <= ~phase_reg;
                    end else if (code_reg == TC_TRK00) begin
                        head_reg <= 1'b1;
                        if (timer_hit) begin
                            step_reg <= 1'b1;
                            dir_reg <= ~phase_reg;
                            track_reg <= phase_reg ? TRK_01 : TRK_02;
                        end
                    end else begin
                        head_reg <= 1'b1;
                    end
                end
                default: begin
                    head_reg <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // oscillator counter for the pll window
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            osc_prev_reg <= 1'b0;
            osc_cnt_reg <= 24'h0;
        end else if (clk_en_in) begin
            osc_prev_reg <= loop_oscillator_in;
            if (state_reg != ST_CHECK || phase_reg || timer_hit) begin
                osc_cnt_reg <= 24'h0;
            end else if (loop_oscillator_in && !osc_prev_reg) begin
                osc_cnt_reg <= osc_cnt_reg + 24'h1;
            end
        end
    end

    // ==========================================================
    // echo sample for the switch test
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            echo_reg <= 8'h0;
        end else if (clk_en_in) begin
            echo_reg <= {<<{switch_in}};
        end
    end

    // ==========================================================
    // indicators and outputs
    logic [7:0] led_next;
    always_comb begin
        led_next = 8'h0;
        if (state_reg == ST_HALT) begin
            led_next[1] = self_err_reg;
            led_next[7:4] = {<<{err_reg}};
        end else if (state_reg == ST_SELF && self_loop) begin
            led_next[4] = toggle_reg;
            led_next[6] = toggle_reg;
            led_next[7] = toggle_reg;
        end else if (state_reg != ST_LATCH && state_reg != ST_NORMAL) begin
            if (code_reg == TC_ECHO && state_reg == ST_CHECK) begin
                led_next = echo_reg;
            end else begin
                led_next[2] = writing_in;
                led_next[3] = reading_in;
                led_next[4] = (density_in == DENS_DOUBLE);
                led_next[5] = (density_in == DENS_SINGLE);
                led_next[7] = drive_reg;
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            led_out <= 8'h0;
            run_led_out <= 1'b0;
        end else if (clk_en_in) begin
            led_out <= led_next;
            run_led_out <= (state_reg != ST_HALT);
        end
    end

    assign drive_sel_out = {drive_reg, !drive_reg};
    assign step_out = step_reg;
    assign dir_in_out = dir_reg;
    assign head_load_out = head_reg;
    assign self_test_start_out = (state_reg == ST_SELF);
    assign rw_test_start_out = (state_reg == ST_CHECK) && (code_reg == TC_RWCTL);
    assign crc_test_start_out = (state_reg == ST_CHECK) && (code_reg == TC_PLLCRC) && phase_reg;
    // host link cable fitted only here
    assign cable_test_start_out = (state_reg == ST_CHECK) && (code_reg == TC_CABLE);
    assign normal_mode_out = (state_reg == ST_NORMAL);
endmodule // fhd_sequencer
`default_nettype wire

// ### testbench/fhd_sequencer_properties.sv
// fhd_sequencer_properties: port assertions for the diagnostic sequencer
// assumes bind into fhd_sequencer, one clock domain
`timescale 1ns/1ps
`default_nettype none
module fhd_sequencer_properties
    import fhd_pkg::*;
#(
    parameter int LOAD_CYCLES = 50
) (
    // watched ports
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic self_test_done_in,
    input wire logic [3:0] self_test_code_in,
    input wire logic [1:0] density_in,
    input wire logic track_zero_in,
    input wire logic [1:0] drive_sel_out,
    input wire logic step_out,
    input wire logic dir_in_out,
    input wire logic head_load_out,
    input wire logic self_test_start_out,
    input wire logic normal_mode_out,
    input wire logic [7:0] led_out,
    input wire logic run_led_out
);
    // ==========
    // helpers
    logic self_ok_reg;
    logic head_prev_reg;
    int hold_reg;
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            self_ok_reg <= 1'b0;
            head_prev_reg <= 1'b0;
            hold_reg <= 0;
        end else begin
            self_ok_reg <= self_ok_reg || (self_test_start_out && self_test_done_in);
            head_prev_reg <= head_load_out;
            hold_reg <= (head_load_out != head_prev_reg) ? 1 : hold_reg + 1;
        end
    end
    // ==========
    // properties
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    chk_halt_holds: assert property ($fell(run_led_out) |=> !run_led_out [*8])
        else $error("run led back after halt");
    chk_self_code: assert property ($fell(run_led_out) && $past(self_test_start_out, 2) |->
        led_out[1] && {led_out[4], led_out[5], led_out[6], led_out[7]} == $past(self_test_code_in, 2))
        else $error("self-test halt code wrong");
    chk_self_first: assert property (head_load_out || step_out |-> self_ok_reg)
        else $error("positioner moved before self-test");
    chk_drive_onehot: assert property ($onehot(drive_sel_out))
        else $error("drive select not one-hot");
    chk_step_pulse: assert property (step_out |=> !step_out)
        else $error("step wider than one cycle");
    chk_home_out: assert property (step_out && !dir_in_out |-> !$past(track_zero_in))
        else $error("outward step at track zero");
    chk_load_span: assert property ($fell(head_load_out) |-> hold_reg == LOAD_CYCLES)
        else $error("head load span wrong");
    chk_run_leds: assert property (run_led_out && head_load_out && $past(head_load_out) |->
        !led_out[6] && led_out[7] == drive_sel_out[1]
        && led_out[4] == ($past(density_in) == DENS_DOUBLE)
        && led_out[5] == ($past(density_in) == DENS_SINGLE))
        else $error("running leds wrong");
    chk_normal_quiet: assert property (normal_mode_out |-> run_led_out && !head_load_out)
        else $error("normal mode not quiet");
    cov_halt: cover property ($fell(run_led_out));
    cov_load: cover property ($rose(head_load_out));
    cov_normal: cover property (normal_mode_out);
endmodule // fhd_sequencer_properties

bind fhd_sequencer fhd_sequencer_properties #(.LOAD_CYCLES(LOAD_CYCLES)) u_props (
    .core_clk_in, .rst_n_in, .self_test_done_in, .self_test_code_in, .density_in,
    .track_zero_in, .drive_sel_out, .step_out, .dir_in_out, .head_load_out,
    .self_test_start_out, .normal_mode_out, .led_out, .run_led_out);
`default_nettype wire

// ### testbench/fhd_drive_model.sv
// fhd_drive_model: positioners of two drives with track zero sensing
// assumes one-cycle step pulses on the sequencer clock
`timescale 1ns/1ps
`default_nettype none
module fhd_drive_model #(
    parameter int START_TRK = 5
) (
    // sequencer side
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic [1:0] drive_sel_in,
    input wire logic step_in,
    input wire logic dir_in_in,
    // sensing
    output logic track_zero_out,
    output var int track_out
);
    int trk [2];
    logic unit;
    assign unit = drive_sel_in[1];
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            trk <= '{START_TRK, START_TRK};
        end else if (step_in && dir_in_in) begin
            trk[unit] <= (trk[unit] < 76) ? trk[unit] + 1 : 76;
        end else if (step_in) begin
            trk[unit] <= (trk[unit] > 0) ? trk[unit] - 1 : 0;
        end
    end
    assign track_out = trk[unit];
    assign track_zero_out = (trk[unit] == 0);
endmodule // fhd_drive_model
`default_nettype wire

// ### testbench/fhd_sequencer_tb.sv
// fhd_sequencer_tb: self-checking bench for the diagnostic sequencer
// assumes short load/step/pll counts set here
`timescale 1ns/1ps
`default_nettype none
module fhd_sequencer_tb;
    import fhd_pkg::*;
    localparam int LC = 50;
    localparam int SC = 40;
    logic clk, rst_n, st_done, st_fail, rw_done, rw_fail, osc, osc_en, crc_done, crc_fail;
    logic cab_done, host_fail, drv_fail, wr, rd, tz, step, dir, hl, st_go, rw_go, crc_go;
    logic cab_go, nm, run;
    logic [3:0] st_code;
    logic [1:0] dens, dsel;
    logic [7:0] sw, led, a;
    logic [31:0] q;
    logic [2:0] seen;
    int i, n, seed, tick, trk, fail_count, comparisons;
    logic [4:0] bad [8] = '{5'h0a, 5'h0b, 5'h14, 5'h15, 5'h16, 5'h17, 5'h1c, 5'h1d};
    logic [4:0] seekc [4] = '{TC_SEEK01, TC_SEEK02, TC_SEEK38, TC_SEEK76};
    logic [7:0] seekt [4] = '{8'h01, 8'h02, 8'h26, 8'h4c};
    fhd_sequencer #(.LOAD_CYCLES(LC), .STEP_CYCLES(SC), .PLL_CYCLES(50), .STEP_GAP(4),
        .PLL_MIN(24'h0a), .PLL_MAX(24'h28)) DUT (
        .core_clk_in(clk), .rst_n_in(rst_n), .clk_en_in(1'b1), .switch_in(sw),
        .self_test_done_in(st_done), .self_test_fail_in(st_fail), .self_test_code_in(st_code),
        .rw_test_done_in(rw_done), .rw_test_fail_in(rw_fail), .loop_oscillator_in(osc),
        .crc_test_done_in(crc_done), .crc_test_fail_in(crc_fail), .cable_test_done_in(cab_done),
        .host_link_cable_fail_in(host_fail), .drive_cable_fail_in(drv_fail), .writing_in(wr),
        .reading_in(rd), .density_in(dens), .track_zero_in(tz), .drive_sel_out(dsel),
        .step_out(step), .dir_in_out(dir), .head_load_out(hl), .self_test_start_out(st_go),
        .rw_test_start_out(rw_go), .crc_test_start_out(crc_go), .cable_test_start_out(cab_go),
        .normal_mode_out(nm), .led_out(led), .run_led_out(run));
    fhd_drive_model u_drives (.core_clk_in(clk), .rst_n_in(rst_n),
        .drive_sel_in(dsel), .step_in(step), .dir_in_in(dir), .track_zero_out(tz),
        .track_out(trk));
    // ==========
    // clock, test hardware responder
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(negedge clk) begin
        tick <= tick + 1;
        st_done <= st_go && (tick % 4 == 3);
        rw_done <= rw_go && (tick % 4 == 3);
        crc_done <= crc_go && (tick % 4 == 3);
        cab_done <= cab_go && (tick % 4 == 3);
        osc <= osc_en && !osc;
    end
    // ==========
    // helpers
    function automatic logic [7:0] run_leds(logic [1:0] d, logic drv, logic w, logic r);
        return {drv, 1'b0, d == DENS_SINGLE, d == DENS_DOUBLE, r, w, 2'h0};
    endfunction
    task automatic check(input logic [7:0] got, exp, input string what);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic start(input logic [4:0] code, input logic drv);
        rst_n = 1'b0;
        sw = {code, 2'($random(seed)), drv};
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
    endtask
    task automatic wait_halt(input logic [3:0] code, input logic led2);
        for (int k = 0; run !== 1'b0 && k < 3000; k++) begin
            @(negedge clk);
        end
        repeat (10) @(negedge clk);
        check({2'h0, run, led[1], led[4], led[5], led[6], led[7]}, {3'h0, led2, code}, "halt");
    endtask
    task automatic wait_load;
        for (int k = 0; hl !== 1'b1 && k < 3000; k++) begin
            @(negedge clk);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #900000;
        fail_count++;
        complete_run();
    end
    // ==========
    // scenarios
    initial begin
        seed = 32'hba52;
        {rst_n, st_fail, rw_fail, crc_fail, host_fail, drv_fail, osc_en, wr, rd} = '0;
        {st_done, rw_done, crc_done, cab_done, osc, st_code, dens, sw} = '0;
        {tick, fail_count, comparisons} = '0;
        for (i = 0; i < 3; i++) begin
            st_fail = 1'b1;
            st_code = 4'($random(seed));
            start(TC_SEEK01, i[0]);
            wait_halt(st_code, 1'b1);
            check({7'h0, hl}, 8'h00, "routine ran");
        end
        st_fail = 1'b0;
        $display("end self-test fail");
        foreach (bad[k]) begin
            start(bad[k], 1'b0);
            wait_halt(ERR_SWITCH, 1'b1);
        end
        rw_fail = 1'b1;
        start(TC_RWCTL, 1'b0);
        wait_halt(ERR_RWCTL, 1'b1);
        rw_fail = 1'b0;
        start(TC_PLLCRC, 1'b1);
        wait_halt(ERR_PLL, 1'b1);
        osc_en = 1'b1;
        crc_fail = 1'b1;
        start(TC_PLLCRC, 1'b0);
        wait_halt(ERR_CRC, 1'b1);
        {crc_fail, host_fail, drv_fail} = 3'h3;
        start(TC_CABLE, 1'b0);
        wait_halt(ERR_CABLE_HOST, 1'b0);
        host_fail = 1'b0;
        start(TC_CABLE, 1'b1);
        wait_halt(ERR_CABLE_DRIVE, 1'b0);
        drv_fail = 1'b0;
        $display("end error halts");
        for (i = 0; i < 4; i++) begin
            start(5'(i), i[1]);
            repeat (20) @(negedge clk);
            check({6'h0, nm, run}, 8'h03, "normal mode");
        end
        foreach (seekc[k]) begin
            q = $random(seed);
            dens = (q[1:0] == 2'h3) ? 2'h0 : q[1:0];
            {wr, rd} = q[3:2];
            start(seekc[k], q[4]);
            wait_load();
            sw = ~sw;
            repeat (30) @(negedge clk);
            check(8'(trk), seekt[k], "track");
            check(led, run_leds(dens, q[4], q[3], q[2]), "leds");
            check({dsel, 4'h0, run, st_go}, {q[4], !q[4], 6'h02}, "drive run");
        end
        $display("end fixed tracks");
        start(TC_HEADLOAD, 1'b1);
        wait_load();
        for (i = 0; i < 2; i++) begin
            a[0] = hl;
            n = 0;
            while (hl === a[0] && n < 500) begin
                @(negedge clk);
                n++;
            end
            check(8'(n), 8'(LC), "load span");
        end
        start(TC_TRK00, 1'b0);
        wait_load();
        repeat (SC + 5) @(negedge clk);
        seen = 3'h0;
        repeat (3 * SC) begin
            @(negedge clk);
            seen = seen | ((trk == 1) ? 3'h4 : (trk == 2) ? 3'h2 : 3'h1);
        end
        check({4'h0, seen, hl}, 8'h0d, "swing");
        $display("end alignment");
        start(TC_STLOOP, 1'b0);
        repeat (20) @(negedge clk);
        a = led;
        repeat (4) @(negedge clk);
        check({5'h0, led[7] ^ a[7], led[6] ^ a[6], led[4] ^ a[4]}, 8'h07, "toggle");
        st_fail = 1'b1;
        st_code = 4'($random(seed));
        wait_halt(st_code, 1'b1);
        $display("end self-test loop");
        complete_run();
    end
endmodule // fhd_sequencer_tb
`default_nettype wire
